//--- testbench/dp_cfg_assertions.sv
// Checker for the port behaviour of the datapath configuration block.
`timescale 1ns/1ps
module dp_cfg_checker
    import dp_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [DATA_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    input wire logic fwd_cfg_valid,
    input wire logic [FWD_W-1:0] fwd_cfg_data,
    input wire logic video_narrow_mode,
    input wire logic audio_four_channel_en,
    input wire logic audio_in_band_sel,
    input wire logic protect_enable
);
    logic wr_ph_ff; // High in the data phase of a datapath write.
    logic nxt_wr_ph;
    logic lock_ff; // Mirror of the lock bit, kept from bus writes only.
    logic nxt_lock;
    logic fwd_go; // A forward update that must land.
    logic [3:0] outs; // The decoded configuration outputs.
    ////////////////////////////////////////
    // The lock is mirrored here because the checker cannot see the register itself.
    always_comb begin
        nxt_wr_ph = hsel && hready && htrans[1] && hwrite
            && haddr[DATA_W-1:ADDR_LSB] == IDX_DATAPATH;
        nxt_lock = wr_ph_ff ? hwdata[BIT_LOCK] : lock_ff;
    end
    // Register the mirror state.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ph_ff <= 1'b0;
            lock_ff <= 1'b0;
        end else begin
            wr_ph_ff <= nxt_wr_ph;
            lock_ff <= nxt_lock;
        end
    end
    assign fwd_go = fwd_cfg_valid && !lock_ff && !wr_ph_ff;
    assign outs = {video_narrow_mode, audio_four_channel_en, audio_in_band_sel, protect_enable};
    ////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    lock_hold_a:
        assert property (fwd_cfg_valid && lock_ff && !wr_ph_ff |=> $stable(outs))
        else $error("Locked forward update changed the outputs.");
    idle_hold_a:
        assert property (!wr_ph_ff && !fwd_cfg_valid |=> $stable(outs))
        else $error("Outputs changed with no update.");
    width_fwd_a:
        assert property (fwd_go |=> video_narrow_mode == $past(fwd_cfg_data[BIT_NARROW]))
        else $error("Width mode did not follow the forward update.");
    transport_fwd_a:
        assert property (fwd_go |=> audio_in_band_sel == $past(fwd_cfg_data[BIT_IN_BAND]))
        else $error("Transport did not follow the forward update.");
    four_fwd_a:
        assert property (fwd_go |=> audio_four_channel_en
            == $past(fwd_cfg_data[BIT_4CH_OVR] & fwd_cfg_data[BIT_4CH_EN]))
        else $error("Four-channel enable wrong after forward update.");
    bypass_prot_a:
        assert property (fwd_go |=> protect_enable == !$past(fwd_cfg_data[BIT_BYPASS]))
        else $error("Protection enable does not oppose bypass.");
    local_write_a:
        assert property (wr_ph_ff |=> {video_narrow_mode, audio_in_band_sel, protect_enable}
            == $past({hwdata[BIT_NARROW], hwdata[BIT_IN_BAND], !hwdata[BIT_BYPASS]}))
        else $error("Local write did not reach the outputs.");
    four_gate_a:
        assert property (wr_ph_ff && !hwdata[BIT_4CH_OVR] |=> !audio_four_channel_en)
        else $error("Four-channel audio on without its override.");
    cover property (fwd_cfg_valid && lock_ff);
    cover property (fwd_go);
    cover property (wr_ph_ff && hwdata[BIT_BYPASS]);
endmodule
bind video_datapath_config_regs dp_cfg_checker i_chk (.clock(clock), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .fwd_cfg_valid(fwd_cfg_valid), .fwd_cfg_data(fwd_cfg_data),
    .video_narrow_mode(video_narrow_mode), .audio_four_channel_en(audio_four_channel_en),
    .audio_in_band_sel(audio_in_band_sel), .protect_enable(protect_enable));

//--- testbench/remote_serializer_model.sv
// Model of the remote serializer sending configuration over the forward channel.
`timescale 1ns/1ps
module remote_serializer_model
    import dp_cfg_pkg::*;
(
    input wire logic clock,
    output logic fwd_cfg_valid,
    output logic [FWD_W-1:0] fwd_cfg_data
);
    initial begin
        fwd_cfg_valid = 1'b0;
        fwd_cfg_data = 7'h55;
    end
    // Sends one or two words after a delay; after the last word the data shows its inverse.
    task automatic send(input int gap, input logic [FWD_W-1:0] a, input logic [FWD_W-1:0] b,
                        input logic two);
        repeat (gap) @(posedge clock);
        fwd_cfg_valid <= 1'b1;
        fwd_cfg_data <= a;
        @(posedge clock);
        if (two) begin
            fwd_cfg_data <= b;
            @(posedge clock);
        end
        fwd_cfg_valid <= 1'b0;
        fwd_cfg_data <= two ? ~b : ~a;
    endtask
endmodule

//--- testbench/video_datapath_config_regs_test.sv
// Self-checking testbench for the datapath configuration block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module video_datapath_config_regs_test
    import dp_cfg_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [DATA_W-1:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [DATA_W-1:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, fwd_cfg_valid, video_data_valid, video_narrow_mode;
    logic audio_four_channel_en, audio_in_band_sel, protect_enable, line_checksum_fail;
    logic [DATA_W-1:0] hrdata;
    logic [FWD_W-1:0] fwd_cfg_data;
    logic pixel_valid_pin = 1'b0;
    logic aux_valid = 1'b0;
    logic [RGB_W-1:0] rgb_pin = 24'h123456;
    logic [RGB_W-1:0] video_data_out;
    int fails = 0;
    int check_count = 0;
    int pulses = 0; // Failure pulses seen so far.
    int cycles = 0;
    assign hready = hreadyout; // The one slave drives the bus ready.
    video_datapath_config_regs i_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fwd_cfg_valid(fwd_cfg_valid),
        .fwd_cfg_data(fwd_cfg_data), .pixel_valid_pin(pixel_valid_pin), .rgb_pin(rgb_pin),
        .aux_valid(aux_valid), .aux_data(24'habcdef), .video_data_out(video_data_out),
        .video_data_valid(video_data_valid), .video_narrow_mode(video_narrow_mode),
        .audio_four_channel_en(audio_four_channel_en), .audio_in_band_sel(audio_in_band_sel),
        .protect_enable(protect_enable), .line_checksum_fail(line_checksum_fail));
    remote_serializer_model i_far (.clock(clock), .fwd_cfg_valid(fwd_cfg_valid),
        .fwd_cfg_data(fwd_cfg_data));
    initial forever #12.5 clock = ~clock;
    // Sampling on the falling edge keeps the count clear of update races.
    always @(negedge clock) if (line_checksum_fail === 1'b1) pulses++;
    // A hang is cut short well beyond the roughly 150 cycles the run needs.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            report_and_stop;
        end
    end
    ////////////////////////////////////////
    // One single transfer; each phase holds until ready is seen high at an edge.
    task automatic xfer(input logic w, input logic [WORD_W-1:0] idx,
                        input logic [REG_W-1:0] wd, output logic [REG_W-1:0] rd);
        logic ok;
        logic [DATA_W-1:0] got;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ_BIT;
        hwrite <= w;
        haddr <= {idx, 2'b00};
        do begin
            @(negedge clock);
            ok = hready;
            @(posedge clock);
        end while (!ok);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do begin
            @(negedge clock);
            ok = hready;
            got = hrdata;
            @(posedge clock);
        end while (!ok);
        rd = got[REG_W-1:0];
        if (!w) `CHK("hrdata upper", 24'h0, got[31:8])
        `CHK("hresp", HRESP_OKAY, hresp)
    endtask
    task automatic wr(input logic [WORD_W-1:0] idx, input logic [REG_W-1:0] v);
        logic [REG_W-1:0] d;
        xfer(1'b1, idx, v, d);
    endtask
    task automatic rd(input string nm, input logic [WORD_W-1:0] idx, input logic [REG_W-1:0] e);
        logic [REG_W-1:0] d;
        xfer(1'b0, idx, 8'h00, d);
        `CHK(nm, e, d)
    endtask
    // Checks the decoded outputs against a register value once they have settled.
    task automatic outs_chk(input logic [REG_W-1:0] v);
        @(negedge clock);
        `CHK("narrow", v[2], video_narrow_mode)
        `CHK("in band", v[1], audio_in_band_sel)
        `CHK("four ch", v[3] & v[0], audio_four_channel_en)
        `CHK("protect", ~v[6], protect_enable)
        @(posedge clock);
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        rd("datapath reset", IDX_DATAPATH, RST_DATAPATH);
        rd("rx mode reset", IDX_RX_MODE, 8'h00);
        outs_chk(8'h00);
        wr(30'h3f, 8'hff);
        rd("unmapped", 30'h3f, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_local;
        logic [REG_W-1:0] v [6] = '{8'h01, 8'h09, 8'h04, 8'h02, 8'h40, 8'hbf};
        foreach (v[i]) begin
            wr(IDX_DATAPATH, v[i]);
            outs_chk(v[i]);
            rd("local write", IDX_DATAPATH, v[i]);
        end
        $display("test local done");
    endtask
    task automatic t_fwd;
        wr(IDX_DATAPATH, 8'h00);
        i_far.send(0, 7'h4d, 7'h00, 1'b0);
        outs_chk(8'h4d);
        rd("fwd load", IDX_DATAPATH, 8'h4d);
        wr(IDX_DATAPATH, 8'h80);
        i_far.send(3, 7'h7f, 7'h00, 1'b0);
        rd("fwd locked", IDX_DATAPATH, 8'h80);
        wr(IDX_DATAPATH, 8'h8d);
        rd("write locked", IDX_DATAPATH, 8'h8d);
        wr(IDX_DATAPATH, 8'h00);
        i_far.send(0, 7'h2b, 7'h15, 1'b1);
        rd("fwd pair", IDX_DATAPATH, 8'h15);
        $display("test forward done");
    endtask
    // Holds a configuration and pin state, then checks the output three edges on.
    task automatic vcase(input logic [REG_W-1:0] c, input logic pv, input logic ax,
                         input logic ev, input logic [RGB_W-1:0] ed);
        wr(IDX_DATAPATH, c);
        pixel_valid_pin <= pv;
        aux_valid <= ax;
        repeat (3) @(posedge clock);
        @(negedge clock);
        `CHK("video valid", ev, video_data_valid)
        `CHK("video data", ed, video_data_out)
        @(posedge clock);
    endtask
    task automatic t_video;
        vcase(8'h00, 1'b1, 1'b0, 1'b1, 24'h123456);
        vcase(8'h00, 1'b0, 1'b0, 1'b0, 24'h000000);
        vcase(8'h20, 1'b0, 1'b0, 1'b1, 24'h123456);
        vcase(8'h20, 1'b1, 1'b0, 1'b0, 24'h000000);
        vcase(8'h04, 1'b1, 1'b0, 1'b1, 24'h103454);
        vcase(8'h40, 1'b0, 1'b0, 1'b1, 24'h123456);
        vcase(8'h00, 1'b0, 1'b1, 1'b0, 24'habcdef);
        vcase(8'h10, 1'b0, 1'b1, 1'b0, 24'h000000);
        vcase(8'h40, 1'b0, 1'b1, 1'b1, 24'h123456);
        aux_valid <= 1'b0;
        $display("test video done");
    endtask
    // Two pixels of bytes 01 02 03 sum to 0c; the first idle cycle carries the checksum.
    task automatic line(input logic [7:0] ck);
        pixel_valid_pin <= 1'b1;
        rgb_pin <= 24'h010203;
        repeat (2) @(posedge clock);
        pixel_valid_pin <= 1'b0;
        rgb_pin <= {16'h0, ck};
        @(posedge clock);
        rgb_pin <= 24'h000000;
        repeat (6) @(posedge clock);
    endtask
    task automatic t_sum;
        int base;
        wr(IDX_DATAPATH, 8'h00);
        wr(IDX_RX_MODE, 8'h80);
        rd("rx mode", IDX_RX_MODE, 8'h80);
        base = pulses;
        line(8'h0c);
        `CHK("good line", base, pulses)
        line(8'h0d);
        `CHK("bad line", base + 1, pulses)
        rd("fail flag", IDX_PROTECT, 8'h01);
        wr(IDX_PROTECT, 8'h01);
        rd("fail cleared", IDX_PROTECT, 8'h00);
        $display("test checksum done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        t_local;
        t_fwd;
        t_video;
        t_sum;
        report_and_stop;
    end
endmodule

//--- verilog/dp_cfg_if.sv
// Interface carrying decoded datapath controls and video between the block's modules.
`timescale 1ns/1ps
interface dp_cfg_if;
    import dp_cfg_pkg::*;

    logic bypass;              // Framing bypass in force.
    logic active;              // Pixel valid, already corrected for its sense.
    logic audio_allow;         // Packetized audio may use the video pins.
    logic narrow;              // Narrow video mode selected.
    logic [RGB_W-1:0] rgb;     // Synchronised pixel data.

    modport ctrl (output bypass, output active, output audio_allow, output narrow, output rgb);
    modport mux (input bypass, input active, input audio_allow, input narrow, input rgb);
    modport chk (input active, input rgb);
endinterface

//--- verilog/dp_cfg_pkg.sv
// Shared constants, register map and state types for the datapath configuration block.
package dp_cfg_pkg;

    // Bus geometry: one aligned 32-bit word per register.
    localparam int DATA_W = 32;
    localparam int WORD_W = 30;
    localparam int ADDR_LSB = 2;
    localparam int REG_W = 8;

    // Register indices; the byte address is four times the index.
    localparam logic [WORD_W-1:0] IDX_DATAPATH = 30'h0000_0022;
    localparam logic [WORD_W-1:0] IDX_RX_MODE = 30'h0000_0023;
    localparam logic [WORD_W-1:0] IDX_PROTECT = 30'h0000_0030;

    // Reset values.
    localparam logic [REG_W-1:0] RST_DATAPATH = 8'h00;
    localparam logic RST_CHK_EN = 1'b0;
    localparam logic RST_FAIL = 1'b0;

    // Field positions of the datapath configuration register.
    localparam int BIT_LOCK = 7;
    localparam int BIT_BYPASS = 6;
    localparam int BIT_SENSE = 5;
    localparam int BIT_AUD_INHIBIT = 4;
    localparam int BIT_4CH_OVR = 3;
    localparam int BIT_NARROW = 2;
    localparam int BIT_IN_BAND = 1;
    localparam int BIT_4CH_EN = 0;
    localparam int FWD_W = 7;

    // Field positions of the receive mode and protection state registers.
    localparam int BIT_CHK_EN = 7;
    localparam int BIT_FAIL = 0;
    localparam int BIT_PROT_OFF = 1;

    // Video geometry.
    localparam int RGB_W = 24;
    localparam int LANE_W = 8;
    localparam int LANES = 3;
    localparam int DROP_W = 2;

    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Line checksum tracker states.
    typedef enum logic [0:0] {
        CK_IDLE,
        CK_LINE
    } chk_state_t;

endpackage

//--- verilog/line_checksum.sv
// Per-line one-byte checksum tracker for the incoming video.
`timescale 1ns/1ps
module line_checksum
    import dp_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    dp_cfg_if.chk cfg,
    input wire logic enable,
    output logic fail_pulse
);

    chk_state_t state_ff, nxt_state;   // Tracker state.
    logic [LANE_W-1:0] sum_ff, nxt_sum; // Running byte sum of the line.
    logic fail_ff, nxt_fail;            // One-cycle mismatch pulse.
    logic [LANE_W-1:0] pix_sum;         // Byte sum of the present pixel.

    // Sum the lanes of a pixel; each line is the sum of all its bytes, modulo 256.
    always_comb begin
        pix_sum = cfg.rgb[LANE_W-1:0] + cfg.rgb[2*LANE_W-1:LANE_W] + cfg.rgb[RGB_W-1:2*LANE_W];
        nxt_state = state_ff;
        nxt_sum = sum_ff;
        nxt_fail = 1'b0;
        case (state_ff)
            CK_IDLE: begin
                // A line opens on the first active pixel while checking is on.
                if (enable && cfg.active) begin
                    nxt_state = CK_LINE;
                    nxt_sum = pix_sum;
                end
            end
            CK_LINE: begin
                if (cfg.active) begin
                    nxt_sum = sum_ff + pix_sum;
                end else begin
                    // The checksum byte rides the low lane in the first idle cycle.
                    nxt_state = CK_IDLE;
                    nxt_fail = enable && (cfg.rgb[LANE_W-1:0] != sum_ff);
                end
            end
            default: begin
                nxt_state = CK_IDLE;
            end
        endcase
    end

    // Register the tracker.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= CK_IDLE;
            sum_ff <= '0;
            fail_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sum_ff <= nxt_sum;
            fail_ff <= nxt_fail;
        end
    end

    assign fail_pulse = fail_ff;

endmodule

//--- verilog/video_datapath_config_regs.sv
// Datapath configuration registers with AHB-Lite access and forward-channel loading.
`timescale 1ns/1ps
module video_datapath_config_regs
    import dp_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,

    // Register bus.
    input wire logic hsel,
    input wire logic [DATA_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,

    // Bus answer.
    output logic hreadyout,
    output logic hresp,
    output logic [DATA_W-1:0] hrdata,

    // Forward channel.
    input wire logic fwd_cfg_valid,
    input wire logic [FWD_W-1:0] fwd_cfg_data,

    // Video pins.
    input wire logic pixel_valid_pin,
    input wire logic [RGB_W-1:0] rgb_pin,

    // Audio packets.
    input wire logic aux_valid,
    input wire logic [RGB_W-1:0] aux_data,

    // Video out.
    output logic [RGB_W-1:0] video_data_out,
    output logic video_data_valid,

    // Decoded controls and the line checksum failure pulse.
    output logic video_narrow_mode,
    output logic audio_four_channel_en,
    output logic audio_in_band_sel,
    output logic protect_enable,
    output logic line_checksum_fail
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    // True when a captured word address selects the given register index.
    function automatic logic reg_hit(input logic [WORD_W-1:0] word,
                                     input logic [WORD_W-1:0] idx);
        reg_hit = (word == idx);
    endfunction

    // Bus address phase capture.
    logic ap_valid_ff, nxt_ap_valid;          // A data phase is in progress.
    logic ap_write_ff, nxt_ap_write;          // That data phase is a write.
    logic [WORD_W-1:0] ap_word_ff, nxt_ap_word; // Word address of the data phase.
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;   // Read data held for the data phase.

    logic addr_phase;                         // A transfer is offered this cycle.

    // Software-visible state.
    logic [REG_W-1:0] cfg_ff, nxt_cfg;        // Datapath configuration register.
    logic chk_en_ff, nxt_chk_en;              // Line checksum enable.
    logic fail_ff, nxt_fail;                  // Sticky checksum failure flag.

    // Pin synchronisers; the first stage feeds only the second.
    logic pv_meta_ff, nxt_pv_meta;
    logic pv_sync_ff, nxt_pv_sync;

    logic [RGB_W-1:0] rgb_meta_ff, nxt_rgb_meta;
    logic [RGB_W-1:0] rgb_sync_ff, nxt_rgb_sync;

    // Write strobes decoded from the data phase.
    logic wr_cfg;
    logic wr_mode;
    logic wr_prot;

    // Checksum result from the tracker.
    logic chk_fail_pulse;

    // Decoded controls shared with the submodules.
    dp_cfg_if dp();

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave.

    // The slave never inserts wait states and never signals an error, so
    // hreadyout stays high and every transfer, mapped or not, ends OKAY.
    // Only whole words move; hsize is not decoded.
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    // Read data comes from a flip-flop.
    assign hrdata = rdata_ff;

    // Only NONSEQ or SEQ transfers with the bus ready open an address phase.
    assign addr_phase = hsel && hready
        && ((htrans & HTRANS_NONSEQ_BIT) != 2'h0);

    // Data phase writes land on the register named in the previous address phase.
    assign wr_cfg = ap_valid_ff && ap_write_ff && reg_hit(ap_word_ff, IDX_DATAPATH);
    assign wr_mode = ap_valid_ff && ap_write_ff && reg_hit(ap_word_ff, IDX_RX_MODE);
    assign wr_prot = ap_valid_ff && ap_write_ff && reg_hit(ap_word_ff, IDX_PROTECT);

    // Capture the address phase and prepare read data.
    // Read data is built from the next register values, so a read placed right
    // after a write to the same register returns the freshly written value;
    // this costs a longer combinational path but needs no wait state.
    always_comb begin
        nxt_ap_valid = addr_phase;
        nxt_ap_write = addr_phase && hwrite;
        nxt_ap_word = addr_phase ? haddr[DATA_W-1:ADDR_LSB] : ap_word_ff;

        // Read data defaults to zero.
        nxt_rdata = '0;
        if (addr_phase && !hwrite) begin
            if (reg_hit(haddr[DATA_W-1:ADDR_LSB], IDX_DATAPATH)) begin
                nxt_rdata[REG_W-1:0] = nxt_cfg;
            end else if (reg_hit(haddr[DATA_W-1:ADDR_LSB], IDX_RX_MODE)) begin
                // Only the checksum enable lives here; other bits read zero.
                nxt_rdata[BIT_CHK_EN] = nxt_chk_en;
            end else if (reg_hit(haddr[DATA_W-1:ADDR_LSB], IDX_PROTECT)) begin
                nxt_rdata[BIT_FAIL] = nxt_fail;
                nxt_rdata[BIT_PROT_OFF] = nxt_cfg[BIT_BYPASS];
            end else begin
                // Unmapped addresses read as zero.
                nxt_rdata = '0;
            end
        end
    end

    // Register the bus phase state.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ap_valid_ff <= 1'b0;
            ap_write_ff <= 1'b0;
            ap_word_ff <= '0;
            rdata_ff <= '0;
        end else begin
            ap_valid_ff <= nxt_ap_valid;
            ap_write_ff <= nxt_ap_write;
            ap_word_ff <= nxt_ap_word;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    // Update the configuration, mode and failure state.
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_chk_en = chk_en_ff;
        nxt_fail = fail_ff;

        // The remote serializer refreshes the low seven fields unless the
        // lock bit protects locally written values.
        if (fwd_cfg_valid && !cfg_ff[BIT_LOCK]) begin
            nxt_cfg[FWD_W-1:0] = fwd_cfg_data;
        end

        // A local write is applied after the forward load, so it always
        // lands and wins a same-cycle collision with the link.
        if (wr_cfg) begin
            nxt_cfg = hwdata[REG_W-1:0];
        end

        // Checksum enable is a plain read-write bit.
        if (wr_mode) begin
            nxt_chk_en = hwdata[BIT_CHK_EN];
        end

        // Writing one clears the failure flag; a failure in the same cycle
        // sets it again, so no event is lost.
        if (wr_prot && hwdata[BIT_FAIL]) begin
            nxt_fail = 1'b0;
        end
        if (chk_fail_pulse) begin
            nxt_fail = 1'b1;
        end
    end

    // Register the software-visible state.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_ff <= RST_DATAPATH;
            chk_en_ff <= RST_CHK_EN;
            fail_ff <= RST_FAIL;
        end else begin
            cfg_ff <= nxt_cfg;
            chk_en_ff <= nxt_chk_en;
            fail_ff <= nxt_fail;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    // Pixel valid and pixel data come from pins, so each passes two stages.
    // Metastability settles in the first stage.
    // The data bus is sampled bit by bit; it is assumed stable around the
    // qualifier, as pixel buses are, so skew between bits does no harm.
    always_comb begin
        nxt_pv_meta = pixel_valid_pin;
        nxt_pv_sync = pv_meta_ff;

        nxt_rgb_meta = rgb_pin;
        nxt_rgb_sync = rgb_meta_ff;
    end

    // Register the synchroniser stages.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pv_meta_ff <= 1'b0;
            pv_sync_ff <= 1'b0;
            rgb_meta_ff <= '0;
            rgb_sync_ff <= '0;
        end else begin
            pv_meta_ff <= nxt_pv_meta;
            pv_sync_ff <= nxt_pv_sync;
            rgb_meta_ff <= nxt_rgb_meta;
            rgb_sync_ff <= nxt_rgb_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control decode.

    // Pixel valid is inverted when the sense bit selects active low.
    assign dp.active = pv_sync_ff ^ cfg_ff[BIT_SENSE];

    // Bypass and width come from the register.
    assign dp.bypass = cfg_ff[BIT_BYPASS];
    assign dp.narrow = cfg_ff[BIT_NARROW];

    // Pixel data arrives synchronised.
    assign dp.rgb = rgb_sync_ff;

    // Packet audio needs both the inhibit bit clear and framing in use.
    assign dp.audio_allow = !cfg_ff[BIT_AUD_INHIBIT] && !cfg_ff[BIT_BYPASS];

    // Content protection cannot run without framed video.
    assign protect_enable = !cfg_ff[BIT_BYPASS];

    // Four-channel audio is forced off unless the override bit is set.
    assign audio_four_channel_en = cfg_ff[BIT_4CH_OVR] && cfg_ff[BIT_4CH_EN];

    // Transport selection: one for in-band, zero for data island.
    assign audio_in_band_sel = cfg_ff[BIT_IN_BAND];

    // Width selection: one for the narrow mode, zero for the full mode.
    assign video_narrow_mode = cfg_ff[BIT_NARROW];

    // A pulse per failed line, for logic that wants to count them.
    assign line_checksum_fail = chk_fail_pulse;

    ////////////////////////////////////////////////////////////////////////////
    // Submodules.

    // Line checksum tracker.
    // It sees the sense-corrected pixel valid.
    line_checksum u_line_checksum (
        .clock(clock),
        .rst(rst),
        .cfg(dp),
        .enable(chk_en_ff),
        .fail_pulse(chk_fail_pulse)
    );

    // Video output stage.
    // Audio packets join ahead of the output flops.
    video_out_mux u_video_out_mux (
        .clock(clock),
        .rst(rst),
        .cfg(dp),
        .aux_valid(aux_valid),
        .aux_data(aux_data),
        .video_data_out(video_data_out),
        .video_data_valid(video_data_valid)
    );

endmodule

//--- verilog/video_out_mux.sv
// Video output stage: framing, width trimming and audio packet insertion.
`timescale 1ns/1ps
module video_out_mux
    import dp_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    dp_cfg_if.mux cfg,
    input wire logic aux_valid,
    input wire logic [RGB_W-1:0] aux_data,
    output logic [RGB_W-1:0] video_data_out,
    output logic video_data_valid
);

    logic [RGB_W-1:0] data_ff, nxt_data; // Registered pixel bus.
    logic valid_ff, nxt_valid;           // Registered pixel qualifier.
    logic [RGB_W-1:0] trimmed;           // Pixel after width trimming.

    // In narrow mode the two low bits of each colour lane are forced to zero.
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign trimmed[g*LANE_W +: DROP_W] =
                cfg.narrow ? '0 : cfg.rgb[g*LANE_W +: DROP_W];
            assign trimmed[g*LANE_W+DROP_W +: LANE_W-DROP_W] =
                cfg.rgb[g*LANE_W+DROP_W +: LANE_W-DROP_W];
        end
    endgenerate

    // Pixels pass when framed or bypassed; audio only fills idle slots.
    always_comb begin
        nxt_data = '0;
        nxt_valid = 1'b0;
        if (cfg.bypass || cfg.active) begin
            nxt_data = trimmed;
            nxt_valid = 1'b1;
        end else if (cfg.audio_allow && aux_valid) begin
            nxt_data = aux_data;
        end
    end

    // Register the output bus.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            data_ff <= nxt_data;
            valid_ff <= nxt_valid;
        end
    end

    assign video_data_out = data_ff;
    assign video_data_valid = valid_ff;

endmodule
